/* File: verilog/ser_pkg.sv */
// status event reporting: shared constants, command codes and bit positions
package ser_pkg;

    localparam int REG_W = 16;
    localparam int BYTE_W = 8;
    localparam int CMD_W = 4;

    // operation group bit positions
    localparam int OPER_LIST_RUNNING = 14;
    localparam int OPER_LIST_COMPLETE = 12;
    localparam int OPER_SAMPLE_COMPLETE = 11;
    localparam int OPER_CONSTANT_CURRENT_STATE = 10;
    localparam int OPER_TRANSIENT_COMPLETE = 9;
    localparam int OPER_CONSTANT_VOLTAGE_STATE = 8;
    localparam int OPER_TRANSIENT_ARMED = 6;
    localparam int OPER_WAITING_FOR_TRIGGER = 5;

    // questionable group bit positions
    localparam int QUES_ENERGY_ABSORBING = 14;
    localparam int QUES_CURRENT_ERROR = 13;
    localparam int QUES_VOLTAGE_ERROR = 12;
    localparam int QUES_SLAVE_ERROR = 6;
    localparam int QUES_THERMAL_ERROR = 3;
    localparam int QUES_CURRENT_MODE_ERROR = 1;
    localparam int QUES_VOLTAGE_MODE_ERROR = 0;

    // status byte summary positions
    localparam int STB_QUES_SUMMARY = 3;
    localparam int STB_OPER_SUMMARY = 7;

    // implemented bits of each group; all others read zero in the condition and event words
    localparam logic [REG_W-1:0] OPER_USED_MASK = 16'h5F60;
    localparam logic [REG_W-1:0] QUES_USED_MASK = 16'h704B;
    // bits that latch into the event registers
    localparam logic [REG_W-1:0] OPER_LATCH_MASK = 16'h5F60;
    localparam logic [REG_W-1:0] QUES_LATCH_MASK = 16'h3000;

    // preset and reset values of the enable masks
    localparam logic [REG_W-1:0] OPER_PRESET_VALUE = 16'h2001;
    localparam logic [REG_W-1:0] QUES_PRESET_VALUE = 16'h00FF;
    localparam logic [REG_W-1:0] MASK_RESET_VALUE = 16'h0000;
    localparam logic [REG_W-1:0] ZERO_WORD = 16'h0000;
    localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;

    typedef enum logic [CMD_W-1:0] {
        SER_CMD_OPER_COND_RD = 4'h0,
        SER_CMD_OPER_EVENT_RD = 4'h1,
        SER_CMD_OPER_MASK_WR = 4'h2,
        SER_CMD_OPER_MASK_RD = 4'h3,
        SER_CMD_QUES_COND_RD = 4'h4,
        SER_CMD_QUES_EVENT_RD = 4'h5,
        SER_CMD_QUES_MASK_WR = 4'h6,
        SER_CMD_QUES_MASK_RD = 4'h7,
        SER_CMD_PRESET = 4'h8,
        SER_CMD_CLEAR_EVENTS = 4'h9,
        SER_CMD_STATUS_BYTE_RD = 4'hA
    } ser_cmd_t;

endpackage : ser_pkg

/* File: verilog/ser_sync.sv */
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module ser_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // first stage feeds only the second stage
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    meta_ff[i] <= 1'b0;
                    sync_ff[i] <= 1'b0;
                end else begin
                    meta_ff[i] <= async_in[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_ff;
endmodule : ser_sync

/* File: verilog/ser_group.sv */
// one status group: live condition, latched event, enable mask, summary
`timescale 1ns/1ps
module ser_group #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] USED_MASK = '1,
    parameter logic [WIDTH-1:0] LATCH_MASK = '1,
    parameter logic [WIDTH-1:0] PRESET_VALUE = '0,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] cond_in,
    input wire logic clear_in,
    input wire logic mask_wr_in,
    input wire logic [WIDTH-1:0] mask_data_in,
    input wire logic preset_in,
    output logic [WIDTH-1:0] cond_out,
    output logic [WIDTH-1:0] event_out,
    output logic [WIDTH-1:0] mask_out,
    output logic summary_out
);
    logic [WIDTH-1:0] cond_prev_ff;
    logic [WIDTH-1:0] event_ff;
    logic [WIDTH-1:0] mask_ff;
    logic [WIDTH-1:0] live;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] nxt_event;

    // live view, unused bits forced low; no exclusion between bits
    assign live = cond_in & USED_MASK;
    assign rise = live & ~cond_prev_ff & LATCH_MASK;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cond_prev_ff <= '0;
        end else begin
            cond_prev_ff <= live;
        end
    end

    // set after clear so an edge in the read cycle survives
    always_comb begin
        nxt_event = clear_in ? '0 : event_ff;
        nxt_event = nxt_event | rise;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            event_ff <= '0;
        end else begin
            event_ff <= nxt_event;
        end
    end

    // preset outranks a write issued in the same cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mask_ff <= RESET_VALUE;
        end else if (preset_in) begin
            mask_ff <= PRESET_VALUE;
        end else if (mask_wr_in) begin
            mask_ff <= mask_data_in;
        end
    end

    assign cond_out = live;
    assign event_out = event_ff;
    assign mask_out = mask_ff;
    assign summary_out = |(event_ff & mask_ff);
endmodule : ser_group

/* File: verilog/ser_top.sv */
// status event reporting top: condition pins, command port, status byte
// Function
// - operation events latch until read
// - operation event read returns value, then clears
// - preset loads 8193 and 255 into masks
// - only questionable bits 13 and 12 latch
// - questionable bits 0 and 1 never latch
// - questionable event read returns value, then clears
// - questionable condition shows live state
// - mode error bits may both be set
// - status bit 3 ORs enabled questionable events
// - questionable mask writable and read back unchanged
// - questionable bit positions fixed as listed
// - operation events use condition bit positions
// - status bit 7 ORs enabled operation events
// - constant current bit 10, constant voltage 8
`timescale 1ns/1ps
module ser_top (
    input wire logic MCLK_IN,
    input wire logic SRST_IN,
    input wire logic LIST_RUNNING_IN,
    input wire logic LIST_COMPLETE_IN,
    input wire logic SAMPLE_COMPLETE_IN,
    input wire logic CONSTANT_CURRENT_STATE_IN,
    input wire logic TRANSIENT_COMPLETE_IN,
    input wire logic CONSTANT_VOLTAGE_STATE_IN,
    input wire logic TRANSIENT_ARMED_IN,
    input wire logic WAITING_FOR_TRIGGER_IN,
    input wire logic ENERGY_ABSORBING_IN,
    input wire logic CURRENT_ERROR_IN,
    input wire logic VOLTAGE_ERROR_IN,
    input wire logic SLAVE_ERROR_IN,
    input wire logic THERMAL_ERROR_IN,
    input wire logic CURRENT_MODE_ERROR_IN,
    input wire logic VOLTAGE_MODE_ERROR_IN,
    input wire logic CMD_VALID_IN,
    input wire logic [ser_pkg::CMD_W-1:0] CMD_CODE_IN,
    input wire logic [ser_pkg::REG_W-1:0] CMD_DATA_IN,
    output logic RSP_VALID_OUT,
    output logic [ser_pkg::REG_W-1:0] RSP_DATA_OUT,
    output logic CMD_ERROR_OUT,
    output logic [ser_pkg::BYTE_W-1:0] STATUS_BYTE_OUT
);
    localparam int W = ser_pkg::REG_W;

    // group words; spare positions stay low so they never latch
    logic [W-1:0] oper_raw;
    logic [W-1:0] ques_raw;
    logic [W-1:0] oper_sync;
    logic [W-1:0] ques_sync;
    logic [W-1:0] oper_cond;
    logic [W-1:0] oper_event;
    logic [W-1:0] oper_mask;
    logic [W-1:0] ques_cond;
    logic [W-1:0] ques_event;
    logic [W-1:0] ques_mask;
    logic oper_summary;
    logic ques_summary;

    // command decode strobes
    logic oper_clear;
    logic ques_clear;
    logic oper_mask_wr;
    logic ques_mask_wr;
    logic preset;
    logic is_read;
    logic known;
    logic [W-1:0] nxt_rsp_data;
    ser_pkg::ser_cmd_t cmd_code;
    logic read_taken;
    logic error_taken;

    // registered outputs
    logic rsp_valid_ff;
    logic [W-1:0] rsp_data_ff;
    logic cmd_error_ff;
    logic [ser_pkg::BYTE_W-1:0] status_byte_ff;
    logic [ser_pkg::BYTE_W-1:0] nxt_status_byte;

    // gather pins into group words at their fixed positions
    always_comb begin
        oper_raw = ser_pkg::ZERO_WORD;
        oper_raw[ser_pkg::OPER_LIST_RUNNING] = LIST_RUNNING_IN;
        oper_raw[ser_pkg::OPER_LIST_COMPLETE] = LIST_COMPLETE_IN;
        oper_raw[ser_pkg::OPER_SAMPLE_COMPLETE] = SAMPLE_COMPLETE_IN;
        oper_raw[ser_pkg::OPER_CONSTANT_CURRENT_STATE] = CONSTANT_CURRENT_STATE_IN;
        oper_raw[ser_pkg::OPER_TRANSIENT_COMPLETE] = TRANSIENT_COMPLETE_IN;
        oper_raw[ser_pkg::OPER_CONSTANT_VOLTAGE_STATE] = CONSTANT_VOLTAGE_STATE_IN;
        oper_raw[ser_pkg::OPER_TRANSIENT_ARMED] = TRANSIENT_ARMED_IN;
        oper_raw[ser_pkg::OPER_WAITING_FOR_TRIGGER] = WAITING_FOR_TRIGGER_IN;
    end

    always_comb begin
        ques_raw = ser_pkg::ZERO_WORD;
        ques_raw[ser_pkg::QUES_ENERGY_ABSORBING] = ENERGY_ABSORBING_IN;
        ques_raw[ser_pkg::QUES_CURRENT_ERROR] = CURRENT_ERROR_IN;
        ques_raw[ser_pkg::QUES_VOLTAGE_ERROR] = VOLTAGE_ERROR_IN;
        ques_raw[ser_pkg::QUES_SLAVE_ERROR] = SLAVE_ERROR_IN;
        ques_raw[ser_pkg::QUES_THERMAL_ERROR] = THERMAL_ERROR_IN;
        ques_raw[ser_pkg::QUES_CURRENT_MODE_ERROR] = CURRENT_MODE_ERROR_IN;
        ques_raw[ser_pkg::QUES_VOLTAGE_MODE_ERROR] = VOLTAGE_MODE_ERROR_IN;
    end

    // power stage pins are asynchronous; unused bits are constant zero
    // trade: full-width stages keep bit positions aligned at a few idle flops
    ser_sync #(
        .WIDTH(W)
    ) u_oper_sync (
        .clk_in(MCLK_IN),
        .srst_in(SRST_IN),
        .async_in(oper_raw),
        .sync_out(oper_sync)
    );

    ser_sync #(
        .WIDTH(W)
    ) u_ques_sync (
        .clk_in(MCLK_IN),
        .srst_in(SRST_IN),
        .async_in(ques_raw),
        .sync_out(ques_sync)
    );

    // typed view of the code; values past the list match no named item
    assign cmd_code = ser_pkg::ser_cmd_t'(CMD_CODE_IN);

    // read select; the word is taken on the same edge as any clear it causes
    always_comb begin
        is_read = 1'b0;
        nxt_rsp_data = ser_pkg::ZERO_WORD;
        if (CMD_VALID_IN) begin
            case (cmd_code)
                ser_pkg::SER_CMD_OPER_COND_RD: begin
                    is_read = 1'b1;
                    nxt_rsp_data = oper_cond;
                end
                ser_pkg::SER_CMD_OPER_EVENT_RD: begin
                    is_read = 1'b1;
                    nxt_rsp_data = oper_event;
                end
                ser_pkg::SER_CMD_OPER_MASK_RD: begin
                    is_read = 1'b1;
                    nxt_rsp_data = oper_mask;
                end
                ser_pkg::SER_CMD_QUES_COND_RD: begin
                    is_read = 1'b1;
                    nxt_rsp_data = ques_cond;
                end
                ser_pkg::SER_CMD_QUES_EVENT_RD: begin
                    is_read = 1'b1;
                    nxt_rsp_data = ques_event;
                end
                ser_pkg::SER_CMD_QUES_MASK_RD: begin
                    is_read = 1'b1;
                    nxt_rsp_data = ques_mask;
                end
                ser_pkg::SER_CMD_STATUS_BYTE_RD: begin
                    is_read = 1'b1;
                    nxt_rsp_data = {{(W - ser_pkg::BYTE_W){1'b0}}, status_byte_ff};
                end
                default: begin
                    is_read = 1'b0;
                end
            endcase
        end
    end

    // side effects; each acts on the edge that takes the command
    always_comb begin
        oper_clear = 1'b0;
        ques_clear = 1'b0;
        oper_mask_wr = 1'b0;
        ques_mask_wr = 1'b0;
        preset = 1'b0;
        known = 1'b1;
        if (CMD_VALID_IN) begin
            case (cmd_code)
                ser_pkg::SER_CMD_OPER_EVENT_RD: begin
                    oper_clear = 1'b1;
                end
                ser_pkg::SER_CMD_OPER_MASK_WR: begin
                    oper_mask_wr = 1'b1;
                end
                ser_pkg::SER_CMD_QUES_EVENT_RD: begin
                    ques_clear = 1'b1;
                end
                ser_pkg::SER_CMD_QUES_MASK_WR: begin
                    ques_mask_wr = 1'b1;
                end
                ser_pkg::SER_CMD_PRESET: begin
                    preset = 1'b1;
                end
                ser_pkg::SER_CMD_CLEAR_EVENTS: begin
                    oper_clear = 1'b1;
                    ques_clear = 1'b1;
                end
                ser_pkg::SER_CMD_OPER_COND_RD,
                ser_pkg::SER_CMD_OPER_MASK_RD,
                ser_pkg::SER_CMD_QUES_COND_RD,
                ser_pkg::SER_CMD_QUES_MASK_RD,
                ser_pkg::SER_CMD_STATUS_BYTE_RD: begin
                    known = 1'b1;
                end
                default: begin
                    known = 1'b0;
                end
            endcase
        end
    end

    // operation group: every used bit latches on its rising edge
    ser_group #(
        .WIDTH(W),
        .USED_MASK(ser_pkg::OPER_USED_MASK),
        .LATCH_MASK(ser_pkg::OPER_LATCH_MASK),
        .PRESET_VALUE(ser_pkg::OPER_PRESET_VALUE),
        .RESET_VALUE(ser_pkg::MASK_RESET_VALUE)
    ) u_oper (
        .clk_in(MCLK_IN),
        .srst_in(SRST_IN),
        .cond_in(oper_sync),
        .clear_in(oper_clear),
        .mask_wr_in(oper_mask_wr),
        .mask_data_in(CMD_DATA_IN),
        .preset_in(preset),
        .cond_out(oper_cond),
        .event_out(oper_event),
        .mask_out(oper_mask),
        .summary_out(oper_summary)
    );

    // questionable group: only the current and voltage error bits (13 and 12) latch, the rest stay live
    ser_group #(
        .WIDTH(W),
        .USED_MASK(ser_pkg::QUES_USED_MASK),
        .LATCH_MASK(ser_pkg::QUES_LATCH_MASK),
        .PRESET_VALUE(ser_pkg::QUES_PRESET_VALUE),
        .RESET_VALUE(ser_pkg::MASK_RESET_VALUE)
    ) u_ques (
        .clk_in(MCLK_IN),
        .srst_in(SRST_IN),
        .cond_in(ques_sync),
        .clear_in(ques_clear),
        .mask_wr_in(ques_mask_wr),
        .mask_data_in(CMD_DATA_IN),
        .preset_in(preset),
        .cond_out(ques_cond),
        .event_out(ques_event),
        .mask_out(ques_mask),
        .summary_out(ques_summary)
    );

    // a refused code changes no state; it only raises the error pulse
    assign read_taken = CMD_VALID_IN & is_read;
    assign error_taken = CMD_VALID_IN & ~known;

    // response: one cycle after the command, held only that cycle
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            rsp_valid_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= read_taken;
        end
    end

    // data keeps the last answer until the next read is taken
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            rsp_data_ff <= ser_pkg::ZERO_WORD;
        end else if (read_taken) begin
            rsp_data_ff <= nxt_rsp_data;
        end
    end

    // unknown codes flag an error pulse and change no state
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            cmd_error_ff <= 1'b0;
        end else begin
            cmd_error_ff <= error_taken;
        end
    end

    // status byte registered, so it lags the event bits by one cycle
    always_comb begin
        nxt_status_byte = ser_pkg::ZERO_BYTE;
        nxt_status_byte[ser_pkg::STB_QUES_SUMMARY] = ques_summary;
        nxt_status_byte[ser_pkg::STB_OPER_SUMMARY] = oper_summary;
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            status_byte_ff <= ser_pkg::ZERO_BYTE;
        end else begin
            status_byte_ff <= nxt_status_byte;
        end
    end

    assign RSP_VALID_OUT = rsp_valid_ff;
    assign RSP_DATA_OUT = rsp_data_ff;
    assign CMD_ERROR_OUT = cmd_error_ff;
    assign STATUS_BYTE_OUT = status_byte_ff;
endmodule : ser_top

/* File: verification/ser_top_checker.sv */
// checker: command port answers, mask echo and status byte relations
`timescale 1ns/1ps
module ser_top_checker (
    input wire logic MCLK_IN,
    input wire logic SRST_IN,
    input wire logic CMD_VALID_IN,
    input wire logic [ser_pkg::CMD_W-1:0] CMD_CODE_IN,
    input wire logic [ser_pkg::REG_W-1:0] CMD_DATA_IN,
    input wire logic RSP_VALID_OUT,
    input wire logic [ser_pkg::REG_W-1:0] RSP_DATA_OUT,
    input wire logic CMD_ERROR_OUT,
    input wire logic [ser_pkg::BYTE_W-1:0] STATUS_BYTE_OUT
);
    logic is_read;
    logic bad_code;
    logic [15:0] oper_mask_ff;
    logic [15:0] ques_mask_ff;
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SRST_IN);
    assign is_read = CMD_VALID_IN &&
        (CMD_CODE_IN inside {4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'hA});
    assign bad_code = CMD_VALID_IN && (CMD_CODE_IN > 4'hA);
    // mirrors of the masks, rebuilt only from commands seen at the port
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN || (CMD_VALID_IN && CMD_CODE_IN == 4'h8)) begin
            oper_mask_ff <= SRST_IN ? 16'h0000 : 16'h2001;
        end else if (CMD_VALID_IN && CMD_CODE_IN == 4'h2) begin
            oper_mask_ff <= CMD_DATA_IN;
        end
    end
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN || (CMD_VALID_IN && CMD_CODE_IN == 4'h8)) begin
            ques_mask_ff <= SRST_IN ? 16'h0000 : 16'h00FF;
        end else if (CMD_VALID_IN && CMD_CODE_IN == 4'h6) begin
            ques_mask_ff <= CMD_DATA_IN;
        end
    end
    a_read_answer: assert property (is_read |=> RSP_VALID_OUT && !CMD_ERROR_OUT)
        else $error("read got no answer");
    a_rsp_cause: assert property (RSP_VALID_OUT |-> $past(is_read))
        else $error("answer without a read");
    a_bad_code: assert property (bad_code |=> CMD_ERROR_OUT && !RSP_VALID_OUT)
        else $error("unknown code not flagged");
    a_error_cause: assert property (CMD_ERROR_OUT |-> $past(bad_code))
        else $error("error flag without cause");
    a_oper_mask_echo: assert property (
        CMD_VALID_IN && CMD_CODE_IN == 4'h3 |=> RSP_DATA_OUT == $past(oper_mask_ff))
        else $error("operation mask readback wrong");
    a_ques_mask_echo: assert property (
        CMD_VALID_IN && CMD_CODE_IN == 4'h7 |=> RSP_DATA_OUT == $past(ques_mask_ff))
        else $error("questionable mask readback wrong");
    a_ques_latch_bits: assert property (
        CMD_VALID_IN && CMD_CODE_IN == 4'h5 |=> (RSP_DATA_OUT & 16'hCFFF) == 16'h0000)
        else $error("questionable event holds a live-only bit");
    a_oper_unused_zero: assert property (
        CMD_VALID_IN && CMD_CODE_IN == 4'h0 |=> (RSP_DATA_OUT & 16'hA09F) == 16'h0000)
        else $error("unused operation bit set");
    a_status_spare: assert property ((STATUS_BYTE_OUT & 8'h77) == 8'h00)
        else $error("spare status bit set");
    cover property (CMD_VALID_IN && CMD_CODE_IN == 4'h8);
    cover property (RSP_VALID_OUT && RSP_DATA_OUT != 16'h0000);
    cover property (STATUS_BYTE_OUT == 8'h88);
endmodule : ser_top_checker

bind ser_top ser_top_checker ser_top_checker_inst (.MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN),
    .CMD_VALID_IN(CMD_VALID_IN), .CMD_CODE_IN(CMD_CODE_IN), .CMD_DATA_IN(CMD_DATA_IN),
    .RSP_VALID_OUT(RSP_VALID_OUT), .RSP_DATA_OUT(RSP_DATA_OUT),
    .CMD_ERROR_OUT(CMD_ERROR_OUT), .STATUS_BYTE_OUT(STATUS_BYTE_OUT));

/* File: verification/ser_host.sv */
// host model: one command per call, answer collected within two cycles
`timescale 1ns/1ps
module ser_host (
    input wire logic clk_in,
    input wire logic rsp_valid_in,
    input wire logic [ser_pkg::REG_W-1:0] rsp_data_in,
    input wire logic cmd_error_in,
    output logic cmd_valid_out,
    output logic [ser_pkg::CMD_W-1:0] cmd_code_out,
    output logic [ser_pkg::REG_W-1:0] cmd_data_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_code_out = 4'h0;
        cmd_data_out = 16'h0000;
    end
    task automatic xfer(input logic [3:0] code, input logic [15:0] data,
                        output logic [15:0] rdata, output logic rsp, output logic err);
        rdata = 16'h0000;
        rsp = 1'b0;
        err = 1'b0;
        @(negedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_code_out <= code;
        cmd_data_out <= data;
        @(negedge clk_in);
        cmd_valid_out <= 1'b0;
        // idle fields inverted so a late capture cannot match by luck
        cmd_code_out <= ~code;
        cmd_data_out <= ~data;
        repeat (2) begin
            if (rsp_valid_in === 1'b1) begin
                rsp = 1'b1;
                rdata = rsp_data_in;
            end
            if (cmd_error_in === 1'b1) begin
                err = 1'b1;
            end
            @(negedge clk_in);
        end
    endtask : xfer
endmodule : ser_host

/* File: verification/ser_top_bench.sv */
// testbench: host command sequences against the status reporting block
`timescale 1ns/1ps
module ser_top_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] oper_cond = 16'h0000;
    logic [15:0] ques_cond = 16'h0000;
    logic cmd_valid;
    logic [3:0] cmd_code;
    logic [15:0] cmd_data;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic cmd_error;
    logic [7:0] status_byte;
    int err_count = 0;
    int num_checks = 0;
    always #20 clk = ~clk;
    ser_top ser_top_inst (.MCLK_IN(clk), .SRST_IN(srst),
        .LIST_RUNNING_IN(oper_cond[14]), .LIST_COMPLETE_IN(oper_cond[12]),
        .SAMPLE_COMPLETE_IN(oper_cond[11]), .CONSTANT_CURRENT_STATE_IN(oper_cond[10]),
        .TRANSIENT_COMPLETE_IN(oper_cond[9]), .CONSTANT_VOLTAGE_STATE_IN(oper_cond[8]),
        .TRANSIENT_ARMED_IN(oper_cond[6]), .WAITING_FOR_TRIGGER_IN(oper_cond[5]),
        .ENERGY_ABSORBING_IN(ques_cond[14]), .CURRENT_ERROR_IN(ques_cond[13]),
        .VOLTAGE_ERROR_IN(ques_cond[12]), .SLAVE_ERROR_IN(ques_cond[6]),
        .THERMAL_ERROR_IN(ques_cond[3]), .CURRENT_MODE_ERROR_IN(ques_cond[1]),
        .VOLTAGE_MODE_ERROR_IN(ques_cond[0]), .CMD_VALID_IN(cmd_valid),
        .CMD_CODE_IN(cmd_code), .CMD_DATA_IN(cmd_data), .RSP_VALID_OUT(rsp_valid),
        .RSP_DATA_OUT(rsp_data), .CMD_ERROR_OUT(cmd_error), .STATUS_BYTE_OUT(status_byte));
    ser_host ser_host_inst (.clk_in(clk), .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data),
        .cmd_error_in(cmd_error), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
        .cmd_data_out(cmd_data));
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flag
    task automatic rd(input logic [3:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        logic e;
        ser_host_inst.xfer(code, 16'h0000, d, v, e);
        chk_flag(v, 1'b1);
        chk_flag(e, 1'b0);
        chk_word(d, exp);
    endtask : rd
    task automatic wr(input logic [3:0] code, input logic [15:0] data, input logic bad);
        logic [15:0] d;
        logic v;
        logic e;
        ser_host_inst.xfer(code, data, d, v, e);
        chk_flag(v, 1'b0);
        chk_flag(e, bad);
    endtask : wr
    // conditions pass two synchroniser stages, so allow six cycles to settle
    task automatic cond(input logic [15:0] o, input logic [15:0] q);
        oper_cond = o;
        ques_cond = q;
        repeat (6) @(negedge clk);
    endtask : cond
    task automatic summarize();
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    initial begin
        #100000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        rd(4'h3, 16'h0000);
        rd(4'h7, 16'h0000);
        wr(4'h6, 16'hA5C3, 1'b0);
        rd(4'h7, 16'hA5C3);
        wr(4'h2, 16'h1234, 1'b0);
        rd(4'h3, 16'h1234);
        wr(4'h8, 16'h0000, 1'b0);
        rd(4'h3, 16'h2001);
        rd(4'h7, 16'h00FF);
        cond(16'h0500, 16'h704B);
        rd(4'h0, 16'h0500);
        rd(4'h4, 16'h704B);
        cond(16'h0100, 16'h0000);
        rd(4'h1, 16'h0500);
        rd(4'h1, 16'h0000);
        rd(4'h4, 16'h0000);
        rd(4'h5, 16'h3000);
        rd(4'h5, 16'h0000);
        cond(16'h0000, 16'h1000);
        chk_word({8'h00, status_byte}, 16'h0000);
        wr(4'h6, 16'h1000, 1'b0);
        chk_word({8'h00, status_byte}, 16'h0008);
        wr(4'h2, 16'h0100, 1'b0);
        cond(16'h0100, 16'h1000);
        chk_word({8'h00, status_byte}, 16'h0088);
        rd(4'hA, 16'h0088);
        rd(4'h5, 16'h1000);
        chk_word({8'h00, status_byte}, 16'h0080);
        wr(4'h9, 16'h0000, 1'b0);
        rd(4'h1, 16'h0000);
        chk_word({8'h00, status_byte}, 16'h0000);
        for (int c = 11; c < 16; c++) begin
            wr(c[3:0], 16'hFFFF, 1'b1);
        end
        rd(4'h3, 16'h0100);
        // synced rise lands on the third edge, the one that takes the clearing read
        oper_cond = 16'h0300;
        @(negedge clk);
        rd(4'h1, 16'h0000);
        rd(4'h1, 16'h0200);
        summarize();
    end
endmodule : ser_top_bench
